// ---- trb_far_model.sv ----
`timescale 1ns/1ns
// Measurement engine and item consumer standing around the block
module trb_far_model (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Measurement engine side
    input wire logic meas_start,
    output logic meas_done,
    output logic [63:0] meas_data,
    // Item consumer side
    input wire logic out_valid,
    input wire logic out_comma,
    input wire logic [15:0] out_data,
    input wire logic out_last,
    output logic out_ready,
    // Stall every other cycle when high
    input wire logic slow
);
    logic [4:0] left_q; // Cycles left in the reading
    logic [11:0] k_q; // Readings made so far, tags each slice
    logic tick_q; // Stall pattern
    logic [17:0] items[$]; // Taken items: last, comma, data
    // A reading lasts 19 cycles, long enough that quick retriggers land while busy
    always @(posedge clock) begin
        meas_done <= 1'b0;
        if (!resetn) begin
            left_q <= 5'h00;
            k_q <= 12'h000;
            meas_data <= 64'h0;
        end else if (meas_start) begin
            left_q <= 5'h13;
        end else if (left_q != 5'h00) begin
            left_q <= left_q - 5'h01;
            if (left_q == 5'h01) begin
                meas_done <= 1'b1;
                k_q <= k_q + 12'h001;
            end
        end
        // Data only valid with done; otherwise it keeps toggling
        if (resetn && left_q == 5'h01) begin
            meas_data <= {4'h3, k_q, 4'h2, k_q, 4'h1, k_q, 4'h0, k_q};
        end else if (resetn) begin
            meas_data <= ~meas_data;
        end
    end
    // Consumer takes items, stalling when asked
    always @(posedge clock) begin
        tick_q <= resetn ? ~tick_q : 1'b0;
        out_ready <= resetn && (!slow || tick_q);
        if (resetn && out_valid && out_ready) begin
            items.push_back({out_last, out_comma, out_data});
        end
    end
endmodule

// ---- trb_map.svh ----
`ifndef TRB_MAP_SVH
`define TRB_MAP_SVH
// Overview of operation
// - Buffer length accepted only from 1 to 512
// - Bus triggers during a reading are dropped
// - SRQ raised after each reading when enabled
// - Buffered readings go to memory until full
// - One common length for all active channels
// - Length one: wait for talk after each reading
// - Longer length: append reading, keep taking triggers
// - Full buffer halts until talk, then sends
// - Lowest active channel buffer sent first
// - Single comma between every pair of items
// - Hardware triggers while busy are dropped

// Register byte offsets
`define TRB_OFS_CTRL 8'h00
`define TRB_OFS_LEN 8'h04
`define TRB_OFS_STAT 8'h08
`define TRB_OFS_TRIG 8'h0C
`define TRB_OFS_IRQ 8'h10
`define TRB_OFS_MASK 8'h14

// Control register fields
`define TRB_CTRL_MODE_LSB 0
`define TRB_CTRL_SRQ_BIT 2
`define TRB_CTRL_CH_LSB 4
`define TRB_CTRL_RST 32'h0000_0010

// Buffer length limits and default
`define TRB_LEN_MIN 10'h001
`define TRB_LEN_MAX 10'h200
`define TRB_LEN_RST 10'h001

// Interrupt status bits
`define TRB_IRQ_READ 0
`define TRB_IRQ_FULL 1
`define TRB_IRQ_DROP 2
`define TRB_IRQ_SENT 3

// Channels and comma code
`define TRB_NCH 4
`define TRB_COMMA 16'h002C
`endif

// ---- trb_mem.sv ----
`timescale 1ns/1ns
module trb_mem (
    // Clock
    input wire logic clock,
    // Write port
    input wire logic wen,
    input wire logic [10:0] waddr,
    input wire logic [15:0] wdata,
    // Read port, data registered
    input wire logic ren,
    input wire logic [10:0] raddr,
    output logic [15:0] rdata
);
    // One 512 word bank per channel
    logic [15:0] mem [0:2047];

    // Write side
    always_ff @(posedge clock) begin
        if (wen) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read, one cycle latency
    always_ff @(posedge clock) begin
        if (ren) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ---- trb_pkg.sv ----
package trb_pkg;
    // Controller states, Gray along idle-measure-store-wait-send
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_MEAS = 3'h1,
        ST_STORE = 3'h3,
        ST_WAIT_TALK = 3'h2,
        ST_SEND = 3'h6
    } trb_state_t;
    // Trigger source selection
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_BUS = 2'h1,
        MODE_HW = 2'h2
    } trb_mode_t;
    // Output sequencing phases
    typedef enum logic [1:0] {
        SP_READ = 2'h0,
        SP_LOAD = 2'h1,
        SP_ITEM = 2'h3,
        SP_COMMA = 2'h2
    } trb_send_t;
endpackage

// ---- trb_props.sv ----
`timescale 1ns/1ns
// Checker on the top-level ports of the triggered reading buffer
module trb_props (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB answer
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Measurement and service request
    input wire logic meas_start,
    input wire logic serial_poll,
    input wire logic srq,
    // Output stream
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic out_comma,
    input wire logic [15:0] out_data,
    input wire logic out_last
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Start is a single pulse, so one trigger can never launch two readings
    property p_start_pulse; meas_start |=> !meas_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
    // No reading is started while the buffer is being sent
    property p_no_start_send; out_valid |-> !meas_start; endproperty
    a_no_start_send: assert property (p_no_start_send) else $error("reading started during dump");
    // A presented item holds until taken
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_comma) && $stable(out_last);
    endproperty
    a_hold: assert property (p_hold) else $error("item changed before taken");
    property p_comma_code; out_valid && out_comma |-> out_data == 16'h002C; endproperty
    a_comma_code: assert property (p_comma_code) else $error("comma item has wrong code");
    // Every reading but the last is followed by exactly one comma
    property p_comma_next; out_valid && out_ready && !out_comma && !out_last |=> out_valid && out_comma; endproperty
    a_comma_next: assert property (p_comma_next) else $error("no comma after reading");
    property p_item_next; out_valid && out_ready && out_comma |=> !out_valid ##[1:3] (out_valid && !out_comma); endproperty
    a_item_next: assert property (p_item_next) else $error("comma not followed by reading");
    property p_last_plain; out_valid && out_last |-> !out_comma; endproperty
    a_last_plain: assert property (p_last_plain) else $error("last item is a comma");
    property p_end_dump; out_valid && out_ready && out_last |=> !out_valid; endproperty
    a_end_dump: assert property (p_end_dump) else $error("items after last");
    // Only a serial poll takes the service request away
    property p_srq_hold; srq && !serial_poll |=> srq; endproperty
    a_srq_hold: assert property (p_srq_hold) else $error("srq dropped without poll");
    // One wait state on every access
    property p_apb_answer; psel && !penable |=> ##1 pready; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("slverr without ready");
    // Main scenarios
    c_comma: cover property (out_valid && out_ready && out_comma);
    c_last: cover property (out_valid && out_ready && out_last);
    c_srq: cover property ($rose(srq));
endmodule

bind trb_top trb_props u_props (.clock, .resetn, .psel, .penable, .pready, .pslverr, .meas_start,
    .serial_poll, .srq, .out_valid, .out_ready, .out_comma, .out_data, .out_last);

// ---- trb_sync.sv ----
`timescale 1ns/1ns
module trb_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);
    // First stage, read only by the second
    logic meta_q;

    // Two flip-flop synchroniser
    always_ff @(posedge clock) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- trb_top.sv ----
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "trb_map.svh"
module trb_top
    import trb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins: hardware trigger and talk-addressed level
    input wire logic hw_trig_pin,
    input wire logic talk_addr_pin,
    // Serial poll pulse from the bus interface, clears SRQ
    input wire logic serial_poll,
    // Measurement engine
    output logic meas_start,
    input wire logic meas_done,
    input wire logic [63:0] meas_data,
    // Output item stream
    output logic out_valid,
    output logic out_comma,
    output logic [15:0] out_data,
    output logic out_last,
    input wire logic out_ready,
    // Service request and interrupt
    output logic srq,
    output logic irq
);
    // Lowest active channel at or above start, 4 when none
    function automatic logic [2:0] first_act(input logic [3:0] mask, input logic [2:0] start);
        logic [2:0] r;
        r = 3'h4;
        for (int i = `TRB_NCH - 1; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= start)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Register state
    logic [31:0] ctrl_q;
    logic [9:0] len_q;
    logic [3:0] irq_stat_q, irq_mask_q; // Sticky events and their enables
    // Controller state
    trb_state_t state_q;
    trb_send_t phase_q;
    logic [9:0] fill_q, send_idx_q, next_idx_q; // Readings stored, item being sent, item after it
    logic [2:0] store_ch_q, send_ch_q, next_ch_q; // Value 4 means no channel left
    logic [3:0] act_q; // Channels frozen for this buffer
    logic [63:0] meas_q; // Reading being stored
    logic hw_prev_q; // Last synchronised pin level
    // Synchronised pins
    logic hw_sync, talk_sync;
    // Bus decode
    logic acc_done, wr_en, mapped, trig_wr;
    // Events
    logic bus_trig, hw_trig, trig_any, trig_take;
    logic store_end, send_end;
    logic [3:0] irq_set;
    // Memory ports
    logic mem_wen, mem_ren;
    logic [10:0] mem_waddr, mem_raddr;
    logic [15:0] mem_wdata, mem_rdata;
    // Control fields
    trb_mode_t mode;
    logic srq_en;
    logic [3:0] ch_en;
    logic [2:0] after_ch; // Next active channel after the one being sent

    assign mode = trb_mode_t'(ctrl_q[`TRB_CTRL_MODE_LSB +: 2]);
    assign srq_en = ctrl_q[`TRB_CTRL_SRQ_BIT];
    assign ch_en = ctrl_q[`TRB_CTRL_CH_LSB +: 4];

    // Pin synchronisers
    trb_sync u_sync_hw (.clock(clock), .resetn(resetn), .async_in(hw_trig_pin), .sync_out(hw_sync));
    trb_sync u_sync_talk (.clock(clock), .resetn(resetn), .async_in(talk_addr_pin), .sync_out(talk_sync));

    // Reading buffer memory
    trb_mem u_mem (.clock(clock), .wen(mem_wen), .waddr(mem_waddr), .wdata(mem_wdata), .ren(mem_ren),
        .raddr(mem_raddr), .rdata(mem_rdata));

    // APB decode; one wait state so read data comes from a register
    assign acc_done = psel && penable && pready;
    assign wr_en = acc_done && pwrite;
    assign mapped = (paddr == `TRB_OFS_CTRL) || (paddr == `TRB_OFS_LEN) || (paddr == `TRB_OFS_STAT)
        || (paddr == `TRB_OFS_TRIG) || (paddr == `TRB_OFS_IRQ) || (paddr == `TRB_OFS_MASK);
    assign trig_wr = wr_en && (paddr == `TRB_OFS_TRIG) && pwdata[0];

    // Ready, error and read data
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `TRB_OFS_CTRL: prdata <= ctrl_q;
                    `TRB_OFS_LEN: prdata <= {22'h0, len_q};
                    `TRB_OFS_STAT: prdata <= {16'h0, 3'h0, state_q, fill_q};
                    `TRB_OFS_IRQ: prdata <= {28'h0, irq_stat_q};
                    `TRB_OFS_MASK: prdata <= {28'h0, irq_mask_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_q <= `TRB_CTRL_RST;
        end else if (wr_en && (paddr == `TRB_OFS_CTRL)) begin
            ctrl_q <= {24'h0, pwdata[7:4], 1'b0, pwdata[2:0]};
        end
    end

    // Buffer length; out of range values leave the old length
    always_ff @(posedge clock) begin
        if (!resetn) begin
            len_q <= `TRB_LEN_RST;
        end else if (wr_en && (paddr == `TRB_OFS_LEN) && (pwdata[31:10] == 22'h0)
            && (pwdata[9:0] >= `TRB_LEN_MIN) && (pwdata[9:0] <= `TRB_LEN_MAX)) begin
            len_q <= pwdata[9:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_mask_q <= 4'h0;
        end else if (wr_en && (paddr == `TRB_OFS_MASK)) begin
            irq_mask_q <= pwdata[3:0];
        end
    end

    // Trigger sources; edge detect on the synchronised level only
    assign bus_trig = trig_wr && (mode == MODE_BUS);
    assign hw_trig = hw_sync && !hw_prev_q && (mode == MODE_HW);
    assign trig_any = bus_trig || hw_trig;
    // Busy triggers are not queued, they are simply lost
    assign trig_take = trig_any && (state_q == ST_IDLE) && (ch_en != 4'h0);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            hw_prev_q <= 1'b0;
        end else begin
            hw_prev_q <= hw_sync;
        end
    end

    // Store and send completion
    assign store_end = (state_q == ST_STORE) && store_ch_q[2];
    assign send_end = (state_q == ST_SEND) && (phase_q == SP_ITEM) && out_ready && out_last;

    // Sticky events; a set in the clearing cycle wins
    assign irq_set[`TRB_IRQ_READ] = store_end;
    assign irq_set[`TRB_IRQ_FULL] = store_end && ((fill_q + 10'h001) >= len_q);
    assign irq_set[`TRB_IRQ_DROP] = trig_any && !trig_take;
    assign irq_set[`TRB_IRQ_SENT] = send_end;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_stat_q <= 4'h0;
        end else if (wr_en && (paddr == `TRB_OFS_IRQ)) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[3:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // Level interrupt, registered
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Service request after each reading, cleared by serial poll
    always_ff @(posedge clock) begin
        if (!resetn) begin
            srq <= 1'b0;
        end else if (store_end && srq_en) begin
            srq <= 1'b1;
        end else if (serial_poll) begin
            srq <= 1'b0;
        end
    end

    // Measurement start pulse
    always_ff @(posedge clock) begin
        if (!resetn) begin
            meas_start <= 1'b0;
        end else begin
            meas_start <= trig_take;
        end
    end

    // Main sequencer
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (trig_take) begin
                        state_q <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (meas_done) begin
                        state_q <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    // Full buffer or length one halts for talk
                    if (store_ch_q[2]) begin
                        if ((fill_q + 10'h001) >= len_q) begin
                            state_q <= ST_WAIT_TALK;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT_TALK: begin
                    if (talk_sync) begin
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (send_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Active channels frozen for the whole buffer
    always_ff @(posedge clock) begin
        if (!resetn) begin
            act_q <= 4'h0;
        end else if (trig_take && (fill_q == 10'h000)) begin
            act_q <= ch_en;
        end
    end

    // Reading capture and per-channel store walk
    always_ff @(posedge clock) begin
        if (!resetn) begin
            meas_q <= 64'h0;
            store_ch_q <= 3'h4;
        end else if ((state_q == ST_MEAS) && meas_done) begin
            meas_q <= meas_data;
            store_ch_q <= first_act(act_q, 3'h0);
        end else if ((state_q == ST_STORE) && !store_ch_q[2]) begin
            store_ch_q <= first_act(act_q, store_ch_q + 3'h1);
        end
    end

    // Each reading goes to memory, not to the output
    assign mem_wen = (state_q == ST_STORE) && !store_ch_q[2];
    assign mem_waddr = {store_ch_q[1:0], fill_q[8:0]};
    assign mem_wdata = meas_q[{store_ch_q[1:0], 4'h0} +: 16];

    // Fill count: one per reading, cleared after the buffer is sent
    always_ff @(posedge clock) begin
        if (!resetn) begin
            fill_q <= 10'h000;
        end else if (store_end) begin
            fill_q <= fill_q + 10'h001;
        end else if (send_end) begin
            fill_q <= 10'h000;
        end
    end

    // Memory read address for the output walk
    assign mem_ren = (state_q == ST_SEND) && (phase_q == SP_READ);
    assign mem_raddr = {send_ch_q[1:0], send_idx_q[8:0]};
    assign after_ch = first_act(act_q, send_ch_q + 3'h1);

    // Output walk: lowest channel first, comma between all items
    always_ff @(posedge clock) begin
        if (!resetn) begin
            phase_q <= SP_READ;
            send_ch_q <= 3'h0;
            send_idx_q <= 10'h000;
            next_ch_q <= 3'h0;
            next_idx_q <= 10'h000;
        end else if ((state_q == ST_WAIT_TALK) && talk_sync) begin
            phase_q <= SP_READ;
            send_ch_q <= first_act(act_q, 3'h0);
            send_idx_q <= 10'h000;
        end else if (state_q == ST_SEND) begin
            unique case (phase_q)
                SP_READ: phase_q <= SP_LOAD;
                SP_LOAD: begin
                    phase_q <= SP_ITEM;
                    // Work out the item that follows this one
                    if ((send_idx_q + 10'h001) < fill_q) begin
                        next_ch_q <= send_ch_q;
                        next_idx_q <= send_idx_q + 10'h001;
                    end else begin
                        next_ch_q <= first_act(act_q, send_ch_q + 3'h1);
                        next_idx_q <= 10'h000;
                    end
                end
                SP_ITEM: begin
                    if (out_ready && !out_last) begin
                        phase_q <= SP_COMMA;
                    end
                end
                SP_COMMA: begin
                    if (out_ready) begin
                        phase_q <= SP_READ;
                        send_ch_q <= next_ch_q;
                        send_idx_q <= next_idx_q;
                    end
                end
            endcase
        end
    end

    // Output registers; the last item carries no trailing comma
    always_ff @(posedge clock) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            out_comma <= 1'b0;
            out_data <= 16'h0000;
            out_last <= 1'b0;
        end else if ((state_q == ST_SEND) && (phase_q == SP_LOAD)) begin
            out_valid <= 1'b1;
            out_comma <= 1'b0;
            out_data <= mem_rdata;
            out_last <= ((send_idx_q + 10'h001) >= fill_q) && after_ch[2];
        end else if ((state_q == ST_SEND) && (phase_q == SP_ITEM) && out_ready) begin
            out_valid <= !out_last;
            out_comma <= !out_last;
            out_data <= `TRB_COMMA;
            out_last <= 1'b0;
        end else if ((state_q == ST_SEND) && (phase_q == SP_COMMA) && out_ready) begin
            out_valid <= 1'b0;
            out_comma <= 1'b0;
        end
    end
endmodule

// ---- trb_triggered_reading_buffer_bench.sv ----
`timescale 1ns/1ns
module trb_triggered_reading_buffer_bench;
    import trb_pkg::*;
    // Stimulus, all given a value at time zero
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic hw_trig_pin = 0, talk_addr_pin = 0, serial_poll = 0, slow = 0;
    // Design outputs and model links
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, meas_start, meas_done, out_valid, out_comma, out_last, out_ready, srq, irq;
    logic [63:0] meas_data;
    logic [15:0] out_data;
    int fails = 0, comparisons = 0;
    always #10 clock = ~clock;
    trb_top dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .hw_trig_pin, .talk_addr_pin, .serial_poll, .meas_start, .meas_done, .meas_data, .out_valid,
        .out_comma, .out_data, .out_last, .out_ready, .srq, .irq);
    trb_far_model far (.clock, .resetn, .meas_start, .meas_done, .meas_data, .out_valid, .out_comma,
        .out_data, .out_last, .out_ready, .slow);
    // One APB transfer; an edge always passes before a new setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    // Poll the state field; the watchdog bounds the wait
    task automatic wait_st(input logic [2:0] s);
        do apb(1'b0, 8'h08, 32'h0); while (rdat[12:10] !== s);
    endtask
    task automatic test_reset;
        rd(8'h00, 32'h10, "ctrl");
        rd(8'h04, 32'h1, "len");
        rd(8'h08, 32'h0, "stat");
        rd(8'h20, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, rerr});
        $display("test reset done");
    endtask
    task automatic test_len;
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h1, "len zero");
        wr(8'h04, 32'h201);
        rd(8'h04, 32'h1, "len over");
        wr(8'h04, 32'h200);
        rd(8'h04, 32'h200, "len max");
        wr(8'h04, 32'h3);
        rd(8'h04, 32'h3, "len three");
        $display("test len done");
    endtask
    // Two channels, three readings each, stalled consumer
    task automatic test_buffered;
        int j;
        slow <= 1'b1;
        wr(8'h00, 32'h51);
        wr(8'h0C, 32'h1);
        wr(8'h0C, 32'h1);
        wait_st(3'h0);
        rd(8'h08, 32'h1, "fill one");
        rd(8'h10, 32'h5, "drop flag");
        wr(8'h10, 32'hF);
        wr(8'h0C, 32'h1);
        wait_st(3'h0);
        wr(8'h0C, 32'h1);
        wait_st(3'h2);
        rd(8'h08, 32'h803, "full");
        wr(8'h0C, 32'h1);
        rd(8'h08, 32'h803, "halted");
        talk_addr_pin <= 1'b1;
        wait_st(3'h0);
        talk_addr_pin <= 1'b0;
        j = 0;
        for (int c = 0; c < 4; c += 2) begin
            for (int i = 0; i < 3; i++) begin
                chk("item", {14'h0, 1'(c == 2 && i == 2), 1'b0, 4'(c), 12'(i)}, {14'h0, far.items[j]});
                j++;
                if (!(c == 2 && i == 2)) begin
                    chk("comma", 32'h1002C, {14'h0, far.items[j]});
                    j++;
                end
            end
        end
        chk("count", 32'd11, 32'(far.items.size()));
        rd(8'h08, 32'h0, "cleared");
        rd(8'h10, 32'hF, "flags");
        $display("test buffered done");
    endtask
    // Length one with service request, interrupt masking and clearing
    task automatic test_single;
        slow <= 1'b0;
        far.items.delete();
        wr(8'h10, 32'hF);
        wr(8'h00, 32'h25);
        wr(8'h04, 32'h1);
        wr(8'h0C, 32'h1);
        wait_st(3'h2);
        chk("srq", 32'h1, {31'h0, srq});
        wr(8'h0C, 32'h1);
        rd(8'h08, 32'h801, "wait talk");
        wr(8'h14, 32'h1);
        repeat (2) @(posedge clock);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(8'h10, 32'h1);
        repeat (2) @(posedge clock);
        chk("irq off", 32'h0, {31'h0, irq});
        serial_poll <= 1'b1;
        @(posedge clock);
        serial_poll <= 1'b0;
        repeat (2) @(posedge clock);
        chk("srq poll", 32'h0, {31'h0, srq});
        talk_addr_pin <= 1'b1;
        wait_st(3'h0);
        talk_addr_pin <= 1'b0;
        chk("single", 32'h21003, {14'h0, far.items[0]});
        chk("single count", 32'd1, 32'(far.items.size()));
        wr(8'h14, 32'h0);
        $display("test single done");
    endtask
    // Pin trigger, second edge lands while busy
    task automatic test_hw;
        wr(8'h10, 32'hF);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h12);
        hw_trig_pin <= 1'b1;
        repeat (4) @(posedge clock);
        hw_trig_pin <= 1'b0;
        repeat (4) @(posedge clock);
        hw_trig_pin <= 1'b1;
        repeat (4) @(posedge clock);
        hw_trig_pin <= 1'b0;
        wait_st(3'h0);
        rd(8'h08, 32'h1, "hw fill");
        rd(8'h10, 32'h5, "hw drop");
        // Refused triggers: an empty mask drops, mode off ignores
        wr(8'h10, 32'hF);
        wr(8'h00, 32'h01);
        wr(8'h0C, 32'h1);
        rd(8'h10, 32'h4, "mask zero");
        wr(8'h10, 32'hF);
        wr(8'h00, 32'h10);
        wr(8'h0C, 32'h1);
        rd(8'h08, 32'h1, "mode off");
        rd(8'h10, 32'h0, "off quiet");
        $display("test hw done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        test_reset();
        test_len();
        test_buffered();
        test_single();
        test_hw();
        wrap_up();
    end
    // Whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        wrap_up();
    end
endmodule
